//--- hw/uil_irq_format.sv
// Interrupt identification and line format control with Wishbone slave
`timescale 1ns/1ps
module uil_irq_format
    import uil_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Interrupt sources and bit-time tick
    input  wire uil_events_t evt_i,
    input  wire logic        bit_tick_i,
    // Transmit path
    input  wire logic        tx_serial_i,
    input  wire logic [7:0]  tx_char_i,
    output logic             tx_line_o,
    output logic             tx_parity_o,
    // Receive parity check
    input  wire logic [7:0]  rx_char_i,
    input  wire logic        rx_parity_i,
    input  wire logic        rx_valid_i,
    output logic             rx_parity_err_o,
    // Format and interrupt status
    output uil_format_t      fmt_o,
    output logic             irq_pending_o
);

    // Whole module state
    typedef struct packed {
        logic [7:0]  lfc;
        logic [7:0]  fsc;
        logic [3:0]  ise;
        logic [15:0] div;
        logic [7:0]  efr;
        logic        ls_flag;
        logic        rx_flag;
        logic        to_flag;
        logic        th_flag;
        logic        ms_flag;
        logic        rx_cond_q;
        logic [7:0]  to_cnt;
        uil_src_t    cur;
        logic        ack;
        logic [31:0] dat;
        logic        tx_line;
        logic        tx_par;
        logic        rx_err;
    } uil_state_t;

    localparam uil_state_t UIL_STATE_RST = '{
        lfc:       UIL_LFC_RST,
        fsc:       UIL_FSC_RST,
        ise:       UIL_ISE_RST,
        div:       UIL_DIV_RST,
        efr:       UIL_EFR_RST,
        ls_flag:   1'b0,
        rx_flag:   1'b0,
        to_flag:   1'b0,
        th_flag:   1'b0,
        ms_flag:   1'b0,
        rx_cond_q: 1'b0,
        to_cnt:    8'h00,
        cur:       UIL_SRC_NONE,
        ack:       1'b0,
        dat:       32'h0000_0000,
        tx_line:   1'b1,
        tx_par:    1'b0,
        rx_err:    1'b0
    };

    uil_state_t s;
    uil_state_t next_s;

    // Trigger level in bytes from the two select bits
    function automatic logic [4:0] trig_level(input logic [1:0] sel);
        case (sel)
            2'b00:   trig_level = UIL_TRIG_0;
            2'b01:   trig_level = UIL_TRIG_1;
            2'b10:   trig_level = UIL_TRIG_2;
            default: trig_level = UIL_TRIG_3;
        endcase
    endfunction

    // Bits in one frame; a half stop bit is counted whole for timing
    // Start, five data bits and the first stop bit make the base of seven
    function automatic logic [3:0] frame_bits(input logic [7:0] lfc);
        logic [3:0] n;
        n = 4'h7 + {2'b00, lfc[1:0]};
        n = n + {3'b000, lfc[UIL_LFC_PEN]};
        n = n + {3'b000, lfc[UIL_LFC_STOP]};
        frame_bits = n;
    endfunction

    // Parity bit expected for a character under the current format
    function automatic logic parity_of(input logic [7:0] ch, input logic [7:0] lfc);
        logic [7:0] mask;
        logic       ones;
        mask = 8'hFF >> (2'd3 - lfc[1:0]);
        ones = ^(ch & mask);
        if (lfc[UIL_LFC_FORCE]) begin
            parity_of = ~lfc[UIL_LFC_EVEN];
        end else if (lfc[UIL_LFC_EVEN]) begin
            parity_of = ones;
        end else begin
            parity_of = ~ones;
        end
    endfunction

    // Identification code of a latched source
    function automatic logic [3:0] code_of(input uil_src_t src);
        case (src)
            UIL_SRC_LS: code_of = UIL_CODE_LS;
            UIL_SRC_RX: code_of = UIL_CODE_RX;
            UIL_SRC_TO: code_of = UIL_CODE_TO;
            UIL_SRC_TH: code_of = UIL_CODE_TH;
            UIL_SRC_MS: code_of = UIL_CODE_MS;
            default:    code_of = UIL_CODE_NONE;
        endcase
    endfunction

    // Bus decode, interrupt source and line format terms
    logic       req;
    logic       wr;
    logic       rd;
    logic       ident_rd;
    logic       fifo_on;
    logic       dlab;
    logic [7:0] ident_byte;
    logic       rx_cond;
    logic [7:0] to_limit;
    logic       ls_pend;
    logic       rx_pend;
    logic       to_pend;
    logic       th_pend;
    logic       ms_pend;
    logic       cur_live;
    logic [3:0] frame_len;
    logic       ls_served;
    logic       rx_served;
    logic       to_served;
    logic       th_served;
    logic       ms_served;

    // Request is taken once; ack falls the cycle after it rose
    assign req      = cyc_i & stb_i & ~s.ack;
    assign wr       = req & we_i;
    assign rd       = req & ~we_i;
    assign ident_rd = rd & (adr_i == UIL_OFS_IDENT);
    assign fifo_on  = s.fsc[UIL_FSC_EN];
    assign dlab     = s.lfc[UIL_LFC_DLAB];

    // Enabled pending sources
    assign ls_pend = s.ls_flag & s.ise[UIL_ISE_LS];
    assign rx_pend = s.rx_flag & s.ise[UIL_ISE_RX];
    assign to_pend = s.to_flag & s.ise[UIL_ISE_RX];
    assign th_pend = s.th_flag & s.ise[UIL_ISE_TH];
    assign ms_pend = s.ms_flag & s.ise[UIL_ISE_MS];

    // Ident read that services a source; only that source's flag drops
    assign ls_served = ident_rd & (s.cur == UIL_SRC_LS);
    assign rx_served = ident_rd & (s.cur == UIL_SRC_RX);
    assign to_served = ident_rd & (s.cur == UIL_SRC_TO);
    assign th_served = ident_rd & (s.cur == UIL_SRC_TH);
    assign ms_served = ident_rd & (s.cur == UIL_SRC_MS);

    // Fill condition for receive data available
    always_comb begin
        if (fifo_on) begin
            rx_cond = evt_i.rx_level >= trig_level(s.fsc[7:6]);
        end else begin
            rx_cond = evt_i.rx_level != 5'h00;
        end
    end

    // Bit times in one character under the current format
    assign frame_len = frame_bits(s.lfc);

    // Four character times of silence, in bit ticks
    assign to_limit = 8'(UIL_TO_CHARS * frame_len);

    // Still-valid check of the source under report
    // A source whose flag or enable drops is let go at once
    always_comb begin
        case (s.cur)
            UIL_SRC_LS: cur_live = ls_pend;
            UIL_SRC_RX: cur_live = rx_pend;
            UIL_SRC_TO: cur_live = to_pend;
            UIL_SRC_TH: cur_live = th_pend;
            UIL_SRC_MS: cur_live = ms_pend;
            default:    cur_live = 1'b0;
        endcase
    end

    // Identification byte as software sees it
    assign ident_byte = {{2{fifo_on}}, 2'b00, code_of(s.cur)};

    // Next-state logic
    always_comb begin
        next_s = s;
        // Ack for one cycle; a strobe still high then is not taken twice
        next_s.ack = req;

        // Sticky sources; a new event beats the clear of the same cycle
        if (ls_served) begin
            next_s.ls_flag = 1'b0;
        end
        if (evt_i.line_status) begin
            next_s.ls_flag = 1'b1;
        end
        if (th_served) begin
            next_s.th_flag = 1'b0;
        end
        if (evt_i.thr_empty) begin
            next_s.th_flag = 1'b1;
        end
        if (ms_served) begin
            next_s.ms_flag = 1'b0;
        end
        if (evt_i.modem_change) begin
            next_s.ms_flag = 1'b1;
        end

        // Data available follows the fill level; armed again on each crossing
        next_s.rx_cond_q = rx_cond;
        if (!rx_cond || rx_served) begin
            next_s.rx_flag = 1'b0;
        end
        if (rx_cond && !s.rx_cond_q) begin
            next_s.rx_flag = 1'b1;
        end

        // Timeout counts idle bit times while data waits, FIFO mode only
        if (!fifo_on || evt_i.rx_activity || evt_i.rx_level == 5'h00) begin
            next_s.to_cnt  = 8'h00;
            next_s.to_flag = 1'b0;
        end else begin
            if (to_served) begin
                next_s.to_flag = 1'b0;
            end
            // Count stops at the limit, so a long silence cannot wrap round
            if (bit_tick_i && s.to_cnt < to_limit) begin
                next_s.to_cnt = s.to_cnt + 8'h01;
                if (s.to_cnt == to_limit - 8'h01) begin
                    next_s.to_flag = 1'b1;
                end
            end
        end

        // Hold the reported source until serviced, then pick the highest
        if (ident_rd || !cur_live) begin
            next_s.cur = UIL_SRC_NONE;
        end
        // After a read the report stays empty one cycle, then re-arbitrates
        if (s.cur == UIL_SRC_NONE && !ident_rd) begin
            if (ls_pend) begin
                next_s.cur = UIL_SRC_LS;
            end else if (rx_pend) begin
                next_s.cur = UIL_SRC_RX;
            end else if (to_pend) begin
                next_s.cur = UIL_SRC_TO;
            end else if (th_pend) begin
                next_s.cur = UIL_SRC_TH;
            end else if (ms_pend) begin
                next_s.cur = UIL_SRC_MS;
            end
        end

        // Register writes, byte lane 0 for byte-wide registers
        if (wr) begin
            case (adr_i)
                UIL_OFS_LFC: begin
                    if (sel_i[0]) begin
                        next_s.lfc = dat_i[7:0];
                    end
                end
                UIL_OFS_FSC: begin
                    if (sel_i[0]) begin
                        next_s.fsc = dat_i[7:0];
                    end
                end
                UIL_OFS_ISE: begin
                    if (sel_i[0]) begin
                        next_s.ise = dat_i[3:0];
                    end
                end
                UIL_OFS_DIV: begin
                    // Hidden while the access gate is closed
                    if (dlab && sel_i[0]) begin
                        next_s.div[7:0] = dat_i[7:0];
                    end
                    if (dlab && sel_i[1]) begin
                        next_s.div[15:8] = dat_i[15:8];
                    end
                end
                UIL_OFS_EFR: begin
                    if (dlab && sel_i[0]) begin
                        next_s.efr = dat_i[7:0];
                    end
                end
                UIL_OFS_IDENT, UIL_OFS_RAW: begin
                    // Status only: the write is acknowledged and dropped
                end
                default: begin
                end
            endcase
        end

        // Read data; unmapped and hidden offsets read zero
        next_s.dat = 32'h0000_0000;
        if (rd) begin
            case (adr_i)
                UIL_OFS_IDENT: next_s.dat = {24'h000000, ident_byte};
                UIL_OFS_LFC:   next_s.dat = {24'h000000, s.lfc};
                UIL_OFS_FSC:   next_s.dat = {24'h000000, s.fsc};
                UIL_OFS_ISE:   next_s.dat = {28'h0000000, s.ise};
                UIL_OFS_DIV:   next_s.dat = dlab ? {16'h0000, s.div} : 32'h0000_0000;
                UIL_OFS_EFR:   next_s.dat = dlab ? {24'h000000, s.efr} : 32'h0000_0000;
                // Raw flags ignore the enables, so software can poll masked sources
                UIL_OFS_RAW:   next_s.dat = {26'h0, rx_cond, s.ms_flag, s.th_flag,
                                             s.to_flag, s.rx_flag, s.ls_flag};
                default:       next_s.dat = 32'h0000_0000;
            endcase
        end

        // Break overrides the serial stream for as long as the bit is set
        next_s.tx_line = s.lfc[UIL_LFC_BRK] ? 1'b0 : tx_serial_i;

        // Transmit parity bit and receive check
        next_s.tx_par = s.lfc[UIL_LFC_PEN] ? parity_of(tx_char_i, s.lfc) : 1'b0;
        if (rx_valid_i) begin
            next_s.rx_err = s.lfc[UIL_LFC_PEN]
                          & (rx_parity_i != parity_of(rx_char_i, s.lfc));
        end
    end

    // State register, synchronous reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= UIL_STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // Format bundle for transmitter and receiver
    always_comb begin
        fmt_o.data_bits    = 4'h5 + {2'b00, s.lfc[1:0]};
        fmt_o.parity_en    = s.lfc[UIL_LFC_PEN];
        fmt_o.parity_even  = s.lfc[UIL_LFC_EVEN];
        fmt_o.parity_force = s.lfc[UIL_LFC_FORCE];
        fmt_o.stop_long    = s.lfc[UIL_LFC_STOP];
        fmt_o.stop_half    = s.lfc[UIL_LFC_STOP] & (s.lfc[1:0] == 2'b00);
        fmt_o.brk          = s.lfc[UIL_LFC_BRK];
        fmt_o.fifo_en      = fifo_on;
        fmt_o.trig_sel     = s.fsc[7:6];
        fmt_o.divisor      = s.div;
        fmt_o.efr          = s.efr;
    end

    // Registered outputs
    assign dat_o           = s.dat;
    assign ack_o           = s.ack;
    assign tx_line_o       = s.tx_line;
    assign tx_parity_o     = s.tx_par;
    assign rx_parity_err_o = s.rx_err;
    assign irq_pending_o   = s.cur != UIL_SRC_NONE;

endmodule

//--- inc/uil_pkg.sv
// Package for the UART interrupt identification and line format block
package uil_pkg;

    // Register byte offsets on the bus
    localparam logic [4:0] UIL_OFS_IDENT = 5'h00;
    localparam logic [4:0] UIL_OFS_LFC   = 5'h04;
    localparam logic [4:0] UIL_OFS_FSC   = 5'h08;
    localparam logic [4:0] UIL_OFS_ISE   = 5'h0C;
    localparam logic [4:0] UIL_OFS_DIV   = 5'h10;
    localparam logic [4:0] UIL_OFS_EFR   = 5'h14;
    localparam logic [4:0] UIL_OFS_RAW   = 5'h18;

    // Line format and FIFO control field positions
    localparam int UIL_LFC_DLAB  = 7;
    localparam int UIL_LFC_BRK   = 6;
    localparam int UIL_LFC_FORCE = 5;
    localparam int UIL_LFC_EVEN  = 4;
    localparam int UIL_LFC_PEN   = 3;
    localparam int UIL_LFC_STOP  = 2;
    localparam int UIL_FSC_EN    = 0;

    // Source enable positions
    localparam int UIL_ISE_RX = 0;
    localparam int UIL_ISE_TH = 1;
    localparam int UIL_ISE_LS = 2;
    localparam int UIL_ISE_MS = 3;

    // Reset values
    localparam logic [7:0]  UIL_LFC_RST = 8'h00;
    localparam logic [7:0]  UIL_FSC_RST = 8'h00;
    localparam logic [3:0]  UIL_ISE_RST = 4'h0;
    localparam logic [15:0] UIL_DIV_RST = 16'h0000;
    localparam logic [7:0]  UIL_EFR_RST = 8'h00;

    // Identification codes, bits 3:0
    localparam logic [3:0] UIL_CODE_NONE = 4'h1;
    localparam logic [3:0] UIL_CODE_LS   = 4'h6;
    localparam logic [3:0] UIL_CODE_RX   = 4'h4;
    localparam logic [3:0] UIL_CODE_TO   = 4'hC;
    localparam logic [3:0] UIL_CODE_TH   = 4'h2;
    localparam logic [3:0] UIL_CODE_MS   = 4'h0;

    // Receive trigger levels in bytes
    localparam logic [4:0] UIL_TRIG_0 = 5'h01;
    localparam logic [4:0] UIL_TRIG_1 = 5'h04;
    localparam logic [4:0] UIL_TRIG_2 = 5'h08;
    localparam logic [4:0] UIL_TRIG_3 = 5'h0E;

    // Idle character times before a receive timeout
    localparam logic [7:0] UIL_TO_CHARS = 8'h04;

    // Latched source under report, one-hot
    typedef enum logic [5:0] {
        UIL_SRC_NONE = 6'b000001,
        UIL_SRC_LS   = 6'b000010,
        UIL_SRC_RX   = 6'b000100,
        UIL_SRC_TO   = 6'b001000,
        UIL_SRC_TH   = 6'b010000,
        UIL_SRC_MS   = 6'b100000
    } uil_src_t;

    // Events and levels from the rest of the UART
    typedef struct packed {
        logic       line_status;
        logic       thr_empty;
        logic       modem_change;
        logic       rx_activity;
        logic [4:0] rx_level;
    } uil_events_t;

    // Format settings handed to transmitter and receiver
    typedef struct packed {
        logic [3:0]  data_bits;
        logic        parity_en;
        logic        parity_even;
        logic        parity_force;
        logic        stop_long;
        logic        stop_half;
        logic        brk;
        logic        fifo_en;
        logic [1:0]  trig_sel;
        logic [15:0] divisor;
        logic [7:0]  efr;
    } uil_format_t;

endpackage

//--- test/tb_top.sv
// Self-checking bench for interrupt identification and line format
`timescale 1ns/1ps
module tb_top;
    import uil_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc, stb, we, ack, ok, tick = 1'b0, tx_ser = 1'b1;
    logic        tx_line, tx_par, rx_err, irq, rx_par = 1'b0, rx_vld = 1'b0;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, rd;
    logic [7:0]  tx_chr = 8'h00, rx_chr = 8'h00, lfc;
    logic [1:0]  r;
    uil_events_t evt = '0;
    uil_format_t fmt;
    logic [7:0]  order [4] = '{8'hC6, 8'hC2, 8'hC0, 8'hC1};
    int          errors = 0;
    int          cmp_count = 0;

    // Clock, bit tick every other cycle, random serial stream
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) tick <= ~tick;
    always @(posedge clk_i) tx_ser <= 1'($urandom);

    uil_host_model host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    uil_irq_format uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .evt_i(evt),
        .bit_tick_i(tick), .tx_serial_i(tx_ser), .tx_char_i(tx_chr), .tx_line_o(tx_line),
        .tx_parity_o(tx_par), .rx_char_i(rx_chr), .rx_parity_i(rx_par), .rx_valid_i(rx_vld),
        .rx_parity_err_o(rx_err), .fmt_o(fmt), .irq_pending_o(irq));

    // Verdict and end of run
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bus cycle; a lost ack ends the run
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        host.xfer(w, a, d, rd, ok);
        if (!ok) begin
            errors++;
            print_verdict();
        end
    endtask

    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    // One-cycle event pulses: line status, holding empty, modem change
    task automatic pulse(input logic [2:0] ev);
        {evt.line_status, evt.thr_empty, evt.modem_change} <= ev;
        @(posedge clk_i);
        {evt.line_status, evt.thr_empty, evt.modem_change} <= 3'b000;
        repeat (3) @(posedge clk_i);
    endtask

    // New receive fill level with one FIFO activity pulse
    task automatic fill(input logic [4:0] lvl);
        evt.rx_level <= lvl;
        evt.rx_activity <= 1'b1;
        @(posedge clk_i);
        evt.rx_activity <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    // Parity bit over the active data bits only
    function automatic logic par_exp(input logic [7:0] f, input logic [7:0] c);
        logic [7:0] m;
        m = c & (8'hFF >> (2'd3 - f[1:0]));
        if (!f[3]) return 1'b0;
        if (f[5]) return !f[4];
        return f[4] ? ^m : ~^m;
    endfunction

    initial begin
        void'($urandom(48));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk("ident reset", UIL_OFS_IDENT, 32'h01);
        rchk("lfc reset", UIL_OFS_LFC, 32'h00);
        rchk("fsc reset", UIL_OFS_FSC, 32'h00);
        rchk("unmapped", 5'h1C, 32'h0);
        bus(1'b1, UIL_OFS_DIV, 32'h1234);
        rchk("div hidden", UIL_OFS_DIV, 32'h0);
        chk("div dropped", 32'h0, fmt.divisor);
        // Every length and parity mode, random break, stop and characters
        for (int i = 0; i < 32; i++) begin
            r = 2'($urandom);
            lfc = {1'b0, r[0], i[4:2], r[1], i[1:0]};
            bus(1'b1, UIL_OFS_LFC, {24'h0, lfc});
            tx_chr <= 8'($urandom);
            rx_chr <= 8'($urandom);
            rx_par <= 1'($urandom);
            rx_vld <= 1'b1;
            @(posedge clk_i);
            rx_vld <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk("tx parity", par_exp(lfc, tx_chr), tx_par);
            chk("rx err", lfc[3] & (rx_par ^ par_exp(lfc, rx_chr)), rx_err);
            chk("data bits", 5 + lfc[1:0], fmt.data_bits);
            chk("stop", {lfc[2], lfc[2] & ~|lfc[1:0]}, {fmt.stop_long, fmt.stop_half});
            chk("par", lfc[5:3], {fmt.parity_force, fmt.parity_even, fmt.parity_en});
            chk("brk fmt", lfc[6], fmt.brk);
            if (lfc[6]) chk("break line", 32'h0, tx_line);
            rchk("lfc", UIL_OFS_LFC, {24'h0, lfc});
        end
        // Divisor and feature register only with the access gate open
        bus(1'b1, UIL_OFS_LFC, 32'h83);
        bus(1'b1, UIL_OFS_DIV, 32'h1234);
        bus(1'b1, UIL_OFS_EFR, 32'h5A);
        rchk("div", UIL_OFS_DIV, 32'h1234);
        chk("fmt div", 32'h1234, fmt.divisor);
        rchk("efr", UIL_OFS_EFR, 32'h5A);
        chk("fmt efr", 32'h5A, fmt.efr);
        bus(1'b1, UIL_OFS_LFC, 32'h03);
        rchk("efr hidden", UIL_OFS_EFR, 32'h0);
        // Masked source stays silent, then reports once enabled
        bus(1'b1, UIL_OFS_ISE, 32'h0);
        pulse(3'b010);
        rchk("ident masked", UIL_OFS_IDENT, 32'h01);
        rchk("raw masked", UIL_OFS_RAW, 32'h08);
        bus(1'b1, UIL_OFS_FSC, 32'h81);
        chk("trig sel", 32'h2, fmt.trig_sel);
        chk("fifo en", 32'h1, fmt.fifo_en);
        bus(1'b1, UIL_OFS_ISE, 32'hF);
        repeat (3) @(posedge clk_i);
        chk("irq pending", 32'h1, irq);
        rchk("ident th", UIL_OFS_IDENT, 32'hC2);
        rchk("ident none", UIL_OFS_IDENT, 32'hC1);
        // Latched report is not preempted by a later higher source
        pulse(3'b010);
        pulse(3'b100);
        rchk("ident held", UIL_OFS_IDENT, 32'hC2);
        rchk("ident ls", UIL_OFS_IDENT, 32'hC6);
        rchk("ident idle", UIL_OFS_IDENT, 32'hC1);
        // Simultaneous sources come out in priority order
        pulse(3'b111);
        foreach (order[k]) rchk("ident order", UIL_OFS_IDENT, {24'h0, order[k]});
        // Trigger of 8: one short, then at level, then timeout
        fill(5'd7);
        rchk("ident below trig", UIL_OFS_IDENT, 32'hC1);
        fill(5'd8);
        rchk("ident rx", UIL_OFS_IDENT, 32'hC4);
        repeat (200) @(posedge clk_i);
        rchk("ident timeout", UIL_OFS_IDENT, 32'hCC);
        fill(5'd0);
        bus(1'b1, UIL_OFS_FSC, 32'h00);
        rchk("ident fifo off", UIL_OFS_IDENT, 32'h01);
        print_verdict();
    end
endmodule

//--- test/uil_host_model.sv
// Host processor model: classic Wishbone single-cycle master
`timescale 1ns/1ps
module uil_host_model (
    // Clock
    input  wire logic        clk_i,
    // Wishbone master
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [4:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o,
    input  wire logic [31:0] dat_i,
    input  wire logic        ack_i
);
    // Idle bus from time zero
    initial begin
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
    end

    // Request held until ack sampled; bounded so a dead slave cannot hang us
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic ok);
        ok = 1'b0;
        rd = '0;
        @(posedge clk_i);
        {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
        for (int n = 0; n < 50 && !ok; n++) begin
            @(posedge clk_i);
            ok = (ack_i === 1'b1);
            rd = dat_i;
        end
        {cyc_o, stb_o, we_o} <= 3'b000;
    endtask
endmodule

//--- test/uil_irq_format_asserts.sv
// Port checker for the interrupt identification and line format block
`timescale 1ns/1ps
module uil_irq_format_asserts
    import uil_pkg::*;
(
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [4:0]  adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    // Line side and status
    input wire logic        tx_serial_i,
    input wire logic        tx_line_o,
    input wire logic        tx_parity_o,
    input wire uil_format_t fmt_o,
    input wire logic        irq_pending_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Ident read answered in this cycle
    sequence s_id_rd;
        ack_o ##0 $past(cyc_i && stb_i && !we_i && adr_i == UIL_OFS_IDENT);
    endsequence

    // Bus handshake and idle data
    property p_ack_once; ack_o |=> !ack_o; endproperty
    property p_ack_time; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_dat_idle; !ack_o |-> dat_o == 32'h0; endproperty
    // Ident fields tied to status and pending state
    property p_id_fifo; s_id_rd |-> dat_o[7:4] == {{2{fmt_o.fifo_en}}, 2'b00}; endproperty
    property p_id_bit0; s_id_rd |-> dat_o[0] == !$past(irq_pending_o); endproperty
    property p_id_clr; s_id_rd |-> !irq_pending_o; endproperty
    // Line output, parity and stop length
    property p_brk; fmt_o.brk |=> !tx_line_o; endproperty
    property p_line; !rst_i && !fmt_o.brk |=> tx_line_o == $past(tx_serial_i); endproperty
    property p_par_off; !fmt_o.parity_en |=> !tx_parity_o; endproperty
    property p_par_force;
        fmt_o.parity_en && fmt_o.parity_force |=> tx_parity_o == !$past(fmt_o.parity_even);
    endproperty
    property p_stop; fmt_o.stop_half == (fmt_o.stop_long && fmt_o.data_bits == 4'd5); endproperty

    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
    a_ack_time: assert property (p_ack_time) else $error("ack late");
    a_dat_idle: assert property (p_dat_idle) else $error("read data not zero");
    a_id_fifo: assert property (p_id_fifo) else $error("ident upper bits");
    a_id_bit0: assert property (p_id_bit0) else $error("ident bit 0");
    a_id_clr: assert property (p_id_clr) else $error("ident read kept report");
    a_brk: assert property (p_brk) else $error("break not low");
    a_line: assert property (p_line) else $error("line not following serial");
    a_par_off: assert property (p_par_off) else $error("parity while off");
    a_par_force: assert property (p_par_force) else $error("forced parity");
    a_stop: assert property (p_stop) else $error("stop length");

    // Main scenarios reached
    c_id_pend: cover property (s_id_rd ##0 !dat_o[0]);
    c_brk: cover property (fmt_o.brk);
    c_force: cover property (fmt_o.parity_en && fmt_o.parity_force);
    c_timeout: cover property (s_id_rd ##0 dat_o[3:0] == UIL_CODE_TO);
endmodule

bind uil_irq_format uil_irq_format_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .tx_serial_i(tx_serial_i),
    .tx_line_o(tx_line_o), .tx_parity_o(tx_parity_o), .fmt_o(fmt_o),
    .irq_pending_o(irq_pending_o)
);
